// File: rtl/scd_params.svh
// offsets, field positions, reset values and layout for the strap decoder
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH

// register byte offsets
`define SCD_REG_STATUS 8'h00
`define SCD_REG_SMBUS 8'h04
`define SCD_REG_CTRL 8'h08
`define SCD_REG_RAW 8'h0C

// status register fields
`define SCD_ST_VALID 0
`define SCD_ST_HP_EN 1
`define SCD_ST_RSVD_SLOT 2
`define SCD_ST_TEST 3
`define SCD_ST_COMPAT 4
`define SCD_ST_PCIX 5
`define SCD_ST_FREQ_APPLIED 6
`define SCD_ST_MODE_LO 8
`define SCD_ST_MODE_HI 10
`define SCD_ST_SLOTS_LO 12
`define SCD_ST_SLOTS_HI 15
`define SCD_ST_FREQ_LO 16
`define SCD_ST_FREQ_HI 17

// control register fields and reset value
`define SCD_CTRL_LED_ON 0
`define SCD_CTRL_RESET 32'h0000_0000

// captured strap vector layout
`define SCD_STRAP_W 13
`define SCD_SV_SLOT_LO 0
`define SCD_SV_SLOT_HI 3
`define SCD_SV_PCIX_FREQ 4
`define SCD_SV_CONV_FREQ 5
`define SCD_SV_PCIX_SENSE 6
`define SCD_SV_TEST 7
`define SCD_SV_COMPAT 8
`define SCD_SV_SMB_LO 9
`define SCD_SV_SMB_HI 12
`define SCD_STRAP_RESET 13'h0000

// slot strap codes
`define SCD_SLOT_RSVD 4'h8
`define SCD_SLOT_PAR1 4'h9
`define SCD_SLOT_PAR2 4'hA
`define SCD_SLOT_NOGLUE 4'hF
`define SCD_SLOT_SER_OFS 4'h8

`endif

// File: rtl/scd_pkg.sv
// types shared by the strap decoder modules
package scd_pkg;

    typedef enum logic [2:0] {
        SCD_HP_OFF,
        SCD_HP_PARALLEL,
        SCD_HP_SERIAL,
        SCD_HP_NO_GLUE,
        SCD_HP_RESERVED
    } scd_hp_mode_e;

    typedef enum logic [1:0] {
        SCD_F33,
        SCD_F66,
        SCD_F100,
        SCD_F133
    } scd_freq_e;

    typedef logic [7:0] scd_smb_addr_t;

endpackage

// File: rtl/scd_cfg_if.sv
// decoded configuration passed from the decoder to the top
`timescale 1ns/1ps
`default_nettype none
interface scd_cfg_if;
    import scd_pkg::*;
    logic hp_en;
    logic rsvd_slot;
    scd_hp_mode_e hp_mode;
    logic [3:0] slot_count;
    logic freq_applied;
    scd_freq_e max_freq;
    scd_smb_addr_t smb_addr;

    modport producer (
        output hp_en, rsvd_slot, hp_mode, slot_count, freq_applied,
        output max_freq, smb_addr
    );
    modport consumer (
        input hp_en, rsvd_slot, hp_mode, slot_count, freq_applied,
        input max_freq, smb_addr
    );
endinterface
`default_nettype wire

// File: rtl/scd_strap_latch.sv
// power-good edge detector and strap capture register
`timescale 1ns/1ps
`default_nettype none
`include "scd_params.svh"
module scd_strap_latch #(
    parameter int STRAP_W = `SCD_STRAP_W
) (
    input wire logic clk_i, // system clock
    input wire logic reset_i, // synchronous reset, active high
    input wire logic power_good_i, // power-good level
    input wire logic [STRAP_W-1:0] straps_i, // live strap pins
    output logic capture_o, // pulse: straps taken this edge unless reset_i is high
    output logic [STRAP_W-1:0] straps_o, // captured straps
    output logic valid_o // a capture has happened
);
    logic pg_q;
    logic valid_q;
    logic [STRAP_W-1:0] straps_q;
    wire rise = power_good_i & ~pg_q;

    if (STRAP_W < 1) begin : g_chk
        $error("scd_strap_latch: STRAP_W must be positive");
    end

    // pg_q resets low so a power-good already high at release still counts
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pg_q <= 1'b0;
            valid_q <= 1'b0;
            straps_q <= '0;
        end else begin
            pg_q <= power_good_i;
            if (rise) begin
                straps_q <= straps_i;
                valid_q <= 1'b1;
            end
            // otherwise held: later pin activity is ignored
        end
    end

    assign capture_o = rise;
    assign straps_o = straps_q;
    assign valid_o = valid_q;
endmodule
`default_nettype wire

// File: rtl/scd_slot_decode.sv
// combinational decode of captured straps into segment settings
`timescale 1ns/1ps
`default_nettype none
`include "scd_params.svh"
module scd_slot_decode (
    input wire logic [3:0] slot_i, // captured slot strap
    input wire logic pcix_sense_i, // captured pci-x mode sense
    input wire logic pcix_freq_i, // captured pci-x top freq strap
    input wire logic conv_freq_i, // captured conventional freq strap
    input wire logic [3:0] smb_i, // captured address straps {5,3,2,1}
    scd_cfg_if.producer cfg // decoded settings
);
    import scd_pkg::*;

    wire hp_on = slot_i[3];
    wire no_glue = (slot_i == `SCD_SLOT_NOGLUE);
    wire rsvd = (slot_i == `SCD_SLOT_RSVD);
    wire parallel = (slot_i == `SCD_SLOT_PAR1) | (slot_i == `SCD_SLOT_PAR2);
    wire applied = ~hp_on | no_glue;
    wire [3:0] off_slots = {1'b0, slot_i[2:0]} + 4'h1;
    wire [3:0] on_slots = slot_i - `SCD_SLOT_SER_OFS;

    assign cfg.hp_en = hp_on & ~rsvd;
    assign cfg.rsvd_slot = rsvd;
    assign cfg.hp_mode = ~hp_on ? SCD_HP_OFF :
                         rsvd ? SCD_HP_RESERVED :
                         no_glue ? SCD_HP_NO_GLUE :
                         parallel ? SCD_HP_PARALLEL : SCD_HP_SERIAL;
    assign cfg.slot_count = ~hp_on ? off_slots :
                            rsvd ? 4'h0 :
                            no_glue ? 4'h1 : on_slots;
    assign cfg.freq_applied = applied;
    // unapplied strap falls back to the slowest rate of the mode
    assign cfg.max_freq = pcix_sense_i ?
        ((applied & pcix_freq_i) ? SCD_F133 : SCD_F100) :
        ((applied & conv_freq_i) ? SCD_F66 : SCD_F33);
    // bit 0 is the r/w position and stays zero
    assign cfg.smb_addr = {2'b11, smb_i[3], 1'b0, smb_i[2:0], 1'b0};
endmodule
`default_nettype wire

// File: rtl/scd_top.sv
// strap capture and decode with a small register port
`timescale 1ns/1ps
`default_nettype none
`include "scd_params.svh"
module scd_top #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i, // 200 MHz clock
    input wire logic reset_i, // synchronous reset, active high
    input wire logic power_good_i, // power-good level
    input wire logic [3:0] hot_plug_slot_strap_i, // slot strap pins
    input wire logic pcix_top_freq_strap_i, // pci-x 133 strap
    input wire logic conv_top_freq_strap_i, // conventional 66 strap
    input wire logic pcix_capable_sense_i, // pci-x mode sense
    input wire logic test_mode_strap_i, // test strap
    input wire logic [3:0] smbus_addr_strap_i, // {a5,a3,a2,a1} straps
    input wire logic attention_led_in_i, // led pin level (compat strap)
    output logic attention_led_out_o, // led pin drive, low lights
    output logic attention_led_oe_o, // led pin output enable
    input wire logic [ADDR_W-1:0] addr_i, // register address
    input wire logic [31:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [31:0] rdata_o, // read data, cycle after rd_i
    output logic strap_capture_o, // pulse on capture
    output logic cfg_valid_o, // a capture has happened; decoded settings load on the same edge this rises
    output logic hot_plug_en_o, // hot plug enabled
    output scd_pkg::scd_hp_mode_e hot_plug_mode_o, // hot plug mode
    output logic [3:0] slot_count_o, // slots on segment
    output scd_pkg::scd_freq_e max_freq_o, // max segment frequency
    output scd_pkg::scd_smb_addr_t smbus_addr_o, // smbus slave address
    output logic test_mode_o, // test strap was high
    output logic link_compat_o // compat strap level
);
    import scd_pkg::*;

    if (ADDR_W < 4) begin : g_chk
        $error("scd_top: ADDR_W too small for the register map");
    end

    logic [`SCD_STRAP_W-1:0] strap_live;
    logic [`SCD_STRAP_W-1:0] strap_cap;
    logic cap_valid;
    logic cap_pulse;
    scd_cfg_if cfg ();

    assign strap_live = {smbus_addr_strap_i, attention_led_in_i,
                         test_mode_strap_i, pcix_capable_sense_i,
                         conv_top_freq_strap_i, pcix_top_freq_strap_i,
                         hot_plug_slot_strap_i};

    scd_strap_latch #(
        .STRAP_W(`SCD_STRAP_W)
    ) u_latch (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .power_good_i(power_good_i),
        .straps_i(strap_live),
        .capture_o(cap_pulse),
        .straps_o(strap_cap),
        .valid_o(cap_valid)
    );

    scd_slot_decode u_dec (
        .slot_i(strap_cap[`SCD_SV_SLOT_HI:`SCD_SV_SLOT_LO]),
        .pcix_sense_i(strap_cap[`SCD_SV_PCIX_SENSE]),
        .pcix_freq_i(strap_cap[`SCD_SV_PCIX_FREQ]),
        .conv_freq_i(strap_cap[`SCD_SV_CONV_FREQ]),
        .smb_i(strap_cap[`SCD_SV_SMB_HI:`SCD_SV_SMB_LO]),
        .cfg(cfg)
    );

    // registered copies of the decode
    logic valid_q;
    logic hp_en_q;
    logic rsvd_q;
    scd_hp_mode_e mode_q;
    logic [3:0] slots_q;
    logic applied_q;
    scd_freq_e freq_q;
    scd_smb_addr_t smb_q;
    logic test_q;
    logic compat_q;
    logic pcix_q;
    logic pulse_q;
    logic drive_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            valid_q <= 1'b0;
            hp_en_q <= 1'b0;
            rsvd_q <= 1'b0;
            mode_q <= SCD_HP_OFF;
            slots_q <= 4'h0;
            applied_q <= 1'b0;
            freq_q <= SCD_F33;
            smb_q <= 8'h00;
            test_q <= 1'b0;
            compat_q <= 1'b0;
            pcix_q <= 1'b0;
            pulse_q <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            valid_q <= cap_valid;
            pulse_q <= cap_pulse;
            // pin goes back to the board whenever power-good drops
            drive_q <= cap_valid & power_good_i;
            // load while the pulse stands: the capture register has settled,
            // and reset values stay put until a real capture
            if (pulse_q) begin
                hp_en_q <= cfg.hp_en;
                rsvd_q <= cfg.rsvd_slot;
                mode_q <= cfg.hp_mode;
                slots_q <= cfg.slot_count;
                applied_q <= cfg.freq_applied;
                freq_q <= cfg.max_freq;
                smb_q <= cfg.smb_addr;
                // reported only; a high level is a board fault
                test_q <= strap_cap[`SCD_SV_TEST];
                compat_q <= strap_cap[`SCD_SV_COMPAT];
                pcix_q <= strap_cap[`SCD_SV_PCIX_SENSE];
            end
        end
    end

    // register port
    logic [31:0] ctrl_q;
    logic [31:0] rdata_q;
    logic [31:0] status_w;
    logic [31:0] rsel_w;

    wire sel_status = (addr_i == ADDR_W'(`SCD_REG_STATUS));
    wire sel_smbus = (addr_i == ADDR_W'(`SCD_REG_SMBUS));
    wire sel_ctrl = (addr_i == ADDR_W'(`SCD_REG_CTRL));
    wire sel_raw = (addr_i == ADDR_W'(`SCD_REG_RAW));

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[`SCD_ST_VALID] = valid_q;
        status_w[`SCD_ST_HP_EN] = hp_en_q;
        status_w[`SCD_ST_RSVD_SLOT] = rsvd_q;
        status_w[`SCD_ST_TEST] = test_q;
        status_w[`SCD_ST_COMPAT] = compat_q;
        status_w[`SCD_ST_PCIX] = pcix_q;
        status_w[`SCD_ST_FREQ_APPLIED] = applied_q;
        status_w[`SCD_ST_MODE_HI:`SCD_ST_MODE_LO] = mode_q;
        status_w[`SCD_ST_SLOTS_HI:`SCD_ST_SLOTS_LO] = slots_q;
        status_w[`SCD_ST_FREQ_HI:`SCD_ST_FREQ_LO] = freq_q;
    end

    // unmapped addresses read as zero
    assign rsel_w = sel_status ? status_w :
                    sel_smbus ? {24'h00_0000, smb_q} :
                    sel_ctrl ? ctrl_q :
                    sel_raw ? {19'h0_0000, strap_cap} : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_q <= `SCD_CTRL_RESET;
        end else if (wr_i && sel_ctrl) begin
            ctrl_q <= {31'h0000_0000, wdata_i[`SCD_CTRL_LED_ON]};
        end
    end

    // data only in the cycle after the read strobe
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rd_i ? rsel_w : 32'h0000_0000;
        end
    end

    // led pin undriven before a capture and from the cycle after power-good drops until the cycle after it rises,
    // so the next capture sees the board level, not our own drive
    assign attention_led_oe_o = drive_q;
    assign attention_led_out_o = drive_q & ~ctrl_q[`SCD_CTRL_LED_ON];

    assign rdata_o = rdata_q;
    assign strap_capture_o = pulse_q;
    assign cfg_valid_o = valid_q;
    assign hot_plug_en_o = hp_en_q;
    assign hot_plug_mode_o = mode_q;
    assign slot_count_o = slots_q;
    assign max_freq_o = freq_q;
    assign smbus_addr_o = smb_q;
    assign test_mode_o = test_q;
    assign link_compat_o = compat_q;
endmodule
`default_nettype wire

// File: verif/scd_top_monitor.sv
// concurrent checks on the strap decoder top ports
`timescale 1ns/1ps
`default_nettype none
module scd_top_monitor
    import scd_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic reset_i, // sync reset
    input wire logic power_good_i, // power-good
    input wire logic [3:0] hot_plug_slot_strap_i, // slot straps
    input wire logic pcix_top_freq_strap_i, // pci-x strap
    input wire logic conv_top_freq_strap_i, // conv strap
    input wire logic pcix_capable_sense_i, // mode sense
    input wire logic [3:0] smbus_addr_strap_i, // addr straps
    input wire logic attention_led_in_i, // led pin level
    input wire logic strap_capture_o, // capture pulse
    input wire logic hot_plug_en_o, // hot plug on
    input wire scd_hp_mode_e hot_plug_mode_o, // mode
    input wire logic [3:0] slot_count_o, // slots
    input wire scd_freq_e max_freq_o, // max freq
    input wire scd_smb_addr_t smbus_addr_o, // smbus address
    input wire logic link_compat_o // compat level
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence pg_rise;
        !power_good_i ##1 power_good_i;
    endsequence
    sequence fixed_rise;
        pg_rise ##0 (!hot_plug_slot_strap_i[3] || &hot_plug_slot_strap_i);
    endsequence
    // pulse one edge after the rise, decoded outputs one edge later still
    capture_pulse_a: assert property (
        pg_rise |=> strap_capture_o ##1 !strap_capture_o)
        else $error("capture pulse missing or too long");
    hold_setting_a: assert property (
        !$past(strap_capture_o) |-> $stable(slot_count_o) &&
        $stable(max_freq_o) && $stable(smbus_addr_o) &&
        $stable(hot_plug_mode_o))
        else $error("setting moved without capture");
    hp_enable_a: assert property (
        pg_rise |-> ##2 hot_plug_en_o ==
        ($past(hot_plug_slot_strap_i[3], 2) &&
        $past(hot_plug_slot_strap_i, 2) != 4'h8))
        else $error("hot plug enable wrong");
    off_slots_a: assert property (
        pg_rise ##0 !hot_plug_slot_strap_i[3] |-> ##2
        slot_count_o == $past(hot_plug_slot_strap_i, 2) + 4'h1 &&
        hot_plug_mode_o == SCD_HP_OFF)
        else $error("disabled slot decode wrong");
    serial_slots_a: assert property (
        pg_rise ##0 hot_plug_slot_strap_i inside {[4'hB:4'hE]} |-> ##2
        slot_count_o == $past(hot_plug_slot_strap_i, 2) - 4'h8 &&
        hot_plug_mode_o == SCD_HP_SERIAL)
        else $error("serial decode wrong");
    freq_pick_a: assert property (
        fixed_rise |-> ##2 max_freq_o == ($past(pcix_capable_sense_i, 2) ?
        ($past(pcix_top_freq_strap_i, 2) ? SCD_F133 : SCD_F100) :
        ($past(conv_top_freq_strap_i, 2) ? SCD_F66 : SCD_F33)))
        else $error("frequency decode wrong");
    smb_addr_a: assert property (
        pg_rise |-> ##2 smbus_addr_o == {2'b11,
        $past(smbus_addr_strap_i[3], 2), 1'b0,
        $past(smbus_addr_strap_i[2:0], 2), 1'b0})
        else $error("smbus address wrong");
    compat_cap_a: assert property (
        pg_rise |-> ##2 link_compat_o == $past(attention_led_in_i, 2))
        else $error("compat strap not taken");
endmodule
bind scd_top scd_top_monitor scd_top_monitor_inst (.*);
`default_nettype wire

// File: verif/scd_board_model.sv
// board strap resistors and power-good source
`timescale 1ns/1ps
`default_nettype none
module scd_board_model (
    input wire logic clk_i, // clock
    input wire logic pg_set_i, // wanted power-good level
    input wire logic [12:0] straps_set_i, // strap levels to present, except bit 7 (test), held low
    input wire logic led_out_i, // device led drive
    input wire logic led_oe_i, // device led enable
    output logic power_good_o, // power-good to device
    output logic [12:0] pins_o, // strap pins as seen
    output logic led_pin_o // resolved led pin level
);
    logic rel_q;
    logic [12:0] pat_q;
    logic [12:0] held;
    assign held = straps_set_i & ~13'h0080;
    always_ff @(posedge clk_i) begin
        rel_q <= pg_set_i;
        pat_q <= rel_q ? ~pat_q : held;
    end
    // released pins carry other traffic, alternating between the inverted and the true strap value
    assign pins_o = rel_q ? ~pat_q : held;
    assign power_good_o = pg_set_i;
    assign led_pin_o = led_oe_i ? led_out_i : pins_o[8];
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the strap decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import scd_pkg::*;
    // rows: slot code, expected mode, expected slot count
    localparam logic [11:0] ROWS [16] = '{12'h001, 12'h102, 12'h203,
        12'h304, 12'h405, 12'h506, 12'h607, 12'h708, 12'h840, 12'h911,
        12'hA12, 12'hB23, 12'hC24, 12'hD25, 12'hE26, 12'hF31};
    logic clk = 0, reset = 1, pg = 0, wr = 0, rd = 0, app, hp, led_o, oe;
    logic [12:0] sv = '0;
    logic [12:0] pins;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic [11:0] r;
    logic [3:0] s, slots;
    logic pgw, led_pin, cap, valid, hp_en, test, compat;
    scd_hp_mode_e mode;
    scd_freq_e freq, fe;
    scd_smb_addr_t smb;
    int n_mismatch = 0, samples_checked = 0;
    always #2.5 clk = ~clk;
    scd_board_model scd_board_model_inst (.clk_i(clk), .pg_set_i(pg),
        .straps_set_i(sv), .led_out_i(led_o), .led_oe_i(oe),
        .power_good_o(pgw), .pins_o(pins), .led_pin_o(led_pin));
    scd_top scd_top_inst (.clk_i(clk), .reset_i(reset), .power_good_i(pgw),
        .hot_plug_slot_strap_i(pins[3:0]), .pcix_top_freq_strap_i(pins[4]),
        .conv_top_freq_strap_i(pins[5]), .pcix_capable_sense_i(pins[6]),
        .test_mode_strap_i(pins[7]), .smbus_addr_strap_i(pins[12:9]),
        .attention_led_in_i(led_pin), .attention_led_out_o(led_o),
        .attention_led_oe_o(oe), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .strap_capture_o(cap),
        .cfg_valid_o(valid), .hot_plug_en_o(hp_en), .hot_plug_mode_o(mode),
        .slot_count_o(slots), .max_freq_o(freq), .smbus_addr_o(smb),
        .test_mode_o(test), .link_compat_o(compat));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 chk(rdata, e);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 0;
        for (int i = 0; i < 16; i++) begin
            r = ROWS[i];
            s = i[3:0] ^ 4'h5;
            app = !r[11] || &r[11:8];
            hp = r[6:4] inside {3'd1, 3'd2, 3'd3};
            fe = i[0] ? (app && i[1] ? SCD_F133 : SCD_F100)
                      : (app && i[1] ? SCD_F66 : SCD_F33);
            @(posedge clk);
            pg <= 0;
            sv <= {s, i[2], 1'b0, i[0], i[1], i[1], r[11:8]};
            @(posedge clk);
            pg <= 1;
            @(posedge clk);
            #1 chk(cap, 1);
            @(posedge clk);
            #1 chk({cap, valid, oe, test}, 4'b0110);
            chk(hp_en, hp);
            chk(mode, r[6:4]);
            chk(slots, r[3:0]);
            chk(freq, fe);
            chk(smb, {2'b11, s[3], 1'b0, s[2:0], 1'b0});
            chk(compat, i[2]);
            rd_chk(8'h00, {14'h0, fe, r[3:0], 1'b0, r[6:4], 1'b0, app, i[0],
                i[2], 1'b0, r[11:8] == 4'h8, hp, 1'b1});
        end
        rd_chk(8'h0C, {19'h0, sv});
        rd_chk(8'h10, 32'h0);
        wr_reg(8'h08, 32'h1);
        #1 chk({oe, led_o}, 2'b10);
        rd_chk(8'h08, 32'h1);
        wr_reg(8'h08, 32'h0);
        #1 chk(led_o, 1);
        chk(slots, 4'h1);
        @(posedge clk);
        reset <= 1;
        repeat (2) @(posedge clk);
        reset <= 0;
        #1 chk({valid, oe, hp_en}, 3'b000);
        @(posedge clk);
        #1 chk(cap, 1);
        @(posedge clk);
        #1 chk({valid, oe}, 2'b11);
        summarize();
    end
endmodule
`default_nettype wire
